// file: rtl/cmb_top.sv
// Message buffer control, mode control and transmit selection.
// Assumes a protocol engine drives the store, transmit and error
// events as one-cycle pulses on the system clock.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps

// How it works
// - Update flag high only while storing
// - Overwrite flag on data frame over stored
// - Interrupt enable gates buffer completion request
// - Frame-stored flag shows a stored frame
// - Transmit request flag shows pending transmission
// - Ready buffer ignores interrupt enable and config writes
// - Set/clear pair 11/3 drives interrupt enable
// - Set/clear pair 9/1 drives transmit request
// - Set/clear pair 8/0 drives ready
// - Bits 4 and 2 clear overwrite, stored
// - Control register reset all zero
// - Mode changes pass through initialisation
// - Init request waits for interframe space
// - Error clear request in init clears counters
// - Highest priority pending transmit buffer chosen
module cmb_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_bus_busy,
  input wire logic [3:0] i_store_start,
  input wire logic [3:0] i_store_end,
  input wire logic i_store_remote,
  input wire logic [3:0] i_tx_end,
  input wire logic i_tx_ok,
  input wire logic [3:0][28:0] i_buf_id,
  input wire logic [3:0] i_buf_ide,
  input wire logic i_tec_inc,
  input wire logic i_rec_inc,
  input wire logic i_err_evt,
  input wire logic [2:0] i_err_code,
  output logic [3:0] o_buf_irq,
  output logic [3:0] o_buf_rdy,
  output logic [3:0] o_buf_trq,
  output logic o_tx_valid,
  output logic [1:0] o_tx_sel,
  output logic [2:0] o_operating_mode_field,
  output logic o_gom,
  output logic [3:0] o_prescale
);
  typedef struct packed {
    logic [3:0] presc;
    logic global_operation_enable;
    logic [2:0] operating_mode_field;
    cmb_pkg::cmb_mode_e st;
    logic [7:0] tec;
    logic [7:0] rec;
    logic [2:0] info;
    logic [3:0][7:0] cfg;
    logic [15:0] rdata;
    logic tx_valid;
    logic [1:0] tx_sel;
  } cmb_top_s;

  cmb_top_s q, d;
  logic [3:0][15:0] mb_ctrl;
  logic [3:0] mb_wr;
  logic [3:0] st_ok;
  logic [3:0] st_start;
  logic [3:0] st_end;
  logic [3:0] rdy;
  logic [3:0] transmit_request;
  logic [3:0] irq;

  // Controller may only write a buffer that is in use and ready
  always_comb begin
    for (int m = 0; m < cmb_pkg::NBUF; m++) begin
      st_ok[m] = rdy[m] & q.cfg[m][cmb_pkg::C_IN_USE];
      st_start[m] = i_store_start[m] & st_ok[m];
      st_end[m] = i_store_end[m] & st_ok[m];
      mb_wr[m] = i_wr &&
        (i_addr == cmb_pkg::A_MB_CTRL + 8'(m));
    end
  end

  genvar g;
  generate
    for (g = 0; g < cmb_pkg::NBUF; g++) begin : g_buf
      cmb_buf_ctrl u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_wr(mb_wr[g]),
        .i_wdata(i_wdata),
        .i_store_start(st_start[g]),
        .i_store_end(st_end[g]),
        .i_store_remote(i_store_remote),
        .i_tx_end(i_tx_end[g]),
        .i_tx_ok(i_tx_ok),
        .o_ctrl(mb_ctrl[g]),
        .o_rdy(rdy[g]),
        .o_trq(transmit_request[g]),
        .o_irq(irq[g])
      );
    end
  endgenerate

  // Arbitration key: lower value wins, as on the wire
  function automatic logic [31:0] arb_key(input logic [28:0] id,
                                          input logic ide,
                                          input logic rtr);
    logic [31:0] k;
    k = '0;
    if (ide) begin
      k = {id[28:18], 1'b1, 1'b1, id[17:0], rtr};
    end else begin
      k = {id[28:18], rtr, 1'b0, 18'h0_0000, 1'b0};
    end
    return k;
  endfunction

  logic [3:0] tx_cand;
  logic [31:0] best_key;
  logic [31:0] cur_key;
  logic [1:0] best_idx;
  logic best_any;
  logic tx_allowed;

  always_comb begin
    tx_allowed = (q.st != cmb_pkg::ST_INIT) &&
      (q.operating_mode_field != cmb_pkg::OPM_RXONLY);
    best_key = '1;
    best_idx = 2'h0;
    best_any = 1'b0;
    cur_key = '0;
    for (int m = 0; m < cmb_pkg::NBUF; m++) begin
      tx_cand[m] = tx_allowed & transmit_request[m] & rdy[m] &
        q.cfg[m][cmb_pkg::C_IN_USE] &
        (q.cfg[m][cmb_pkg::C_TYPE_LO +: 3] == cmb_pkg::TYPE_TX);
      cur_key = arb_key(i_buf_id[m], i_buf_ide[m],
                        q.cfg[m][cmb_pkg::C_RTR]);
      if (tx_cand[m] && (!best_any || cur_key < best_key)) begin
        best_key = cur_key;
        best_idx = 2'(m);
        best_any = 1'b1;
      end
    end
  end

  logic [2:0] req_mode;
  logic req_valid;
  logic mod_wr;

  always_comb begin
    d = q;
    d.rdata = cmb_pkg::ZERO16;
    d.tx_valid = best_any;
    d.tx_sel = best_idx;
    req_mode = i_wdata[2:0];
    req_valid = (req_mode != cmb_pkg::OPM_INIT) &&
      (req_mode <= cmb_pkg::OPM_TEST);
    mod_wr = i_wr && (i_addr == cmb_pkg::A_MOD_CTRL);

    // Clock choice is frozen once the module is enabled
    if (i_wr && i_addr == cmb_pkg::A_CLK_SEL && !q.global_operation_enable) begin
      d.presc = i_wdata[3:0];
    end
    if (i_wr && i_addr == cmb_pkg::A_GLB_CTRL) begin
      d.global_operation_enable = i_wdata[cmb_pkg::G_GOM];
    end
    for (int m = 0; m < cmb_pkg::NBUF; m++) begin
      if (i_wr && i_addr == cmb_pkg::A_MB_CONF + 8'(m) &&
          !rdy[m]) begin
        d.cfg[m] = i_wdata[7:0] & cmb_pkg::CONF_MASK;
      end
    end

    // Error counters run only outside initialisation
    if (q.st != cmb_pkg::ST_INIT) begin
      if (i_tec_inc && q.tec != cmb_pkg::CNT_MAX) begin
        d.tec = q.tec + 8'h01;
      end
      if (i_rec_inc && q.rec != cmb_pkg::CNT_MAX) begin
        d.rec = q.rec + 8'h01;
      end
      if (i_err_evt) begin
        d.info = i_err_code;
      end
    end

    case (q.st)
      cmb_pkg::ST_INIT: begin
        if (mod_wr && q.global_operation_enable && req_valid) begin
          d.operating_mode_field = req_mode;
          d.st = cmb_pkg::ST_RUN;
        end
        if (mod_wr && i_wdata[cmb_pkg::M_ERROR_COUNTER_CLEAR_REQUEST]) begin
          d.tec = 8'h00;
          d.rec = 8'h00;
          d.info = 3'h0;
        end
      end
      cmb_pkg::ST_RUN: begin
        // Direct change between two run modes is refused
        if (mod_wr && req_mode == cmb_pkg::OPM_INIT) begin
          if (i_bus_busy) begin
            d.st = cmb_pkg::ST_PEND;
          end else begin
            d.st = cmb_pkg::ST_INIT;
            d.operating_mode_field = cmb_pkg::OPM_INIT;
          end
        end
      end
      cmb_pkg::ST_PEND: begin
        if (!i_bus_busy) begin
          d.st = cmb_pkg::ST_INIT;
          d.operating_mode_field = cmb_pkg::OPM_INIT;
        end
      end
      default: begin
        d.st = cmb_pkg::ST_INIT;
        d.operating_mode_field = cmb_pkg::OPM_INIT;
      end
    endcase

    // Disabling the module drops it straight into initialisation
    if (!q.global_operation_enable) begin
      d.st = cmb_pkg::ST_INIT;
      d.operating_mode_field = cmb_pkg::OPM_INIT;
    end

    if (i_rd) begin
      if (i_addr == cmb_pkg::A_CLK_SEL) begin
        d.rdata = {12'h000, q.presc};
      end else if (i_addr == cmb_pkg::A_GLB_CTRL) begin
        d.rdata = {15'h0000, q.global_operation_enable};
      end else if (i_addr == cmb_pkg::A_MOD_CTRL) begin
        d.rdata = {13'h0000, q.operating_mode_field};
      end else if (i_addr == cmb_pkg::A_ERR_CNT) begin
        d.rdata = {q.rec, q.tec};
      end else if (i_addr == cmb_pkg::A_BUS_INFO) begin
        d.rdata = {13'h0000, q.info};
      end else if (i_addr >= cmb_pkg::A_MB_CTRL &&
                   i_addr < cmb_pkg::A_MB_CTRL + 8'h04) begin
        d.rdata = mb_ctrl[i_addr[1:0]];
      end else if (i_addr >= cmb_pkg::A_MB_CONF &&
                   i_addr < cmb_pkg::A_MB_CONF + 8'h04) begin
        d.rdata = {8'h00, q.cfg[i_addr[1:0]]};
      end else begin
        d.rdata = cmb_pkg::ZERO16;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q.presc <= cmb_pkg::PRESC_RST;
      q.global_operation_enable <= 1'b0;
      q.operating_mode_field <= cmb_pkg::OPM_INIT;
      q.st <= cmb_pkg::ST_INIT;
      q.tec <= 8'h00;
      q.rec <= 8'h00;
      q.info <= 3'h0;
      q.cfg <= '0;
      q.rdata <= cmb_pkg::ZERO16;
      q.tx_valid <= 1'b0;
      q.tx_sel <= 2'h0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_buf_irq = irq;
  assign o_buf_rdy = rdy;
  assign o_buf_trq = transmit_request;
  assign o_tx_valid = q.tx_valid;
  assign o_tx_sel = q.tx_sel;
  assign o_operating_mode_field = q.operating_mode_field;
  assign o_gom = q.global_operation_enable;
  assign o_prescale = q.presc;
endmodule // cmb_top

// file: rtl/cmb_pkg.sv
// Constants and types for the message buffer control block.
// Assumes a 20 MHz system clock and a 16-bit register port.
package cmb_pkg;
  localparam int NBUF = 4;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int IDW = 29;
  // Register word addresses
  localparam logic [7:0] A_CLK_SEL = 8'h00;
  localparam logic [7:0] A_GLB_CTRL = 8'h01;
  localparam logic [7:0] A_MOD_CTRL = 8'h02;
  localparam logic [7:0] A_ERR_CNT = 8'h03;
  localparam logic [7:0] A_BUS_INFO = 8'h04;
  localparam logic [7:0] A_MB_CTRL = 8'h10;
  localparam logic [7:0] A_MB_CONF = 8'h20;
  // Buffer control read fields
  localparam int B_MUC = 13;
  localparam int B_MOW = 4;
  localparam int B_IE = 3;
  localparam int B_DN = 2;
  localparam int B_TRQ = 1;
  localparam int B_RDY = 0;
  // Buffer control write fields
  localparam int W_SET_IE = 11;
  localparam int W_SET_TRQ = 9;
  localparam int W_SET_RDY = 8;
  localparam int W_CLR_MOW = 4;
  localparam int W_CLR_IE = 3;
  localparam int W_CLR_DN = 2;
  localparam int W_CLR_TRQ = 1;
  localparam int W_CLR_RDY = 0;
  // Buffer config fields
  localparam int C_IN_USE = 0;
  localparam int C_TYPE_LO = 3;
  localparam int C_RTR = 6;
  localparam logic [2:0] TYPE_TX = 3'h0;
  localparam logic [7:0] CONF_MASK = 8'h79;
  // Global and module control fields
  localparam int G_GOM = 0;
  localparam int M_ERROR_COUNTER_CLEAR_REQUEST = 8;
  localparam logic [3:0] PRESC_RST = 4'h0;
  localparam logic [2:0] OPM_INIT = 3'h0;
  localparam logic [2:0] OPM_NORMAL = 3'h1;
  localparam logic [2:0] OPM_ABT = 3'h2;
  localparam logic [2:0] OPM_RXONLY = 3'h3;
  localparam logic [2:0] OPM_SHOT = 3'h4;
  localparam logic [2:0] OPM_TEST = 3'h5;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] CNT_MAX = 8'hff;

  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_RUN = 3'h2,
    ST_PEND = 3'h4
  } cmb_mode_e;

  typedef struct packed {
    logic buffer_update_in_progress;
    logic overwrite_occurred;
    logic ie;
    logic dn;
    logic transmit_request;
    logic rdy;
    logic irq;
  } cmb_buf_s;
endpackage

// file: rtl/cmb_buf_ctrl.sv
// Flag logic of one message buffer control register.
// Assumes store and transmit events are one-cycle pulses.
`timescale 1ns/10ps
module cmb_buf_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic i_store_start,
  input wire logic i_store_end,
  input wire logic i_store_remote,
  input wire logic i_tx_end,
  input wire logic i_tx_ok,
  output logic [15:0] o_ctrl,
  output logic o_rdy,
  output logic o_trq,
  output logic o_irq
);
  cmb_pkg::cmb_buf_s q, d;

  always_comb begin
    d = q;
    d.irq = 1'b0;
    if (i_tx_end) begin
      d.transmit_request = 1'b0;
      d.irq = q.ie & i_tx_ok;
    end
    if (i_wr) begin
      if (!q.rdy) begin
        if (i_wdata[cmb_pkg::W_SET_IE] && !i_wdata[cmb_pkg::W_CLR_IE]) begin
          d.ie = 1'b1;
        end else if (!i_wdata[cmb_pkg::W_SET_IE] &&
                     i_wdata[cmb_pkg::W_CLR_IE]) begin
          d.ie = 1'b0;
        end
      end
      if (i_wdata[cmb_pkg::W_SET_TRQ] && !i_wdata[cmb_pkg::W_CLR_TRQ]) begin
        d.transmit_request = 1'b1;
      end else if (!i_wdata[cmb_pkg::W_SET_TRQ] &&
                   i_wdata[cmb_pkg::W_CLR_TRQ]) begin
        d.transmit_request = 1'b0;
      end
      // Ready is locked while a frame is being stored
      if (!q.buffer_update_in_progress) begin
        if (i_wdata[cmb_pkg::W_SET_RDY] &&
            !i_wdata[cmb_pkg::W_CLR_RDY]) begin
          d.rdy = 1'b1;
        end else if (!i_wdata[cmb_pkg::W_SET_RDY] &&
                     i_wdata[cmb_pkg::W_CLR_RDY]) begin
          d.rdy = 1'b0;
        end
      end
      if (i_wdata[cmb_pkg::W_CLR_MOW]) begin
        d.overwrite_occurred = 1'b0;
      end
      if (i_wdata[cmb_pkg::W_CLR_DN]) begin
        d.dn = 1'b0;
      end
    end
    // Hardware sets come last so they win over a clear
    if (i_store_start) begin
      d.buffer_update_in_progress = 1'b1;
      d.dn = 1'b1;
      if (q.dn && !i_store_remote) begin
        d.overwrite_occurred = 1'b1;
      end
    end
    if (i_store_end) begin
      d.buffer_update_in_progress = 1'b0;
      d.dn = 1'b1;
      d.irq = q.ie;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  always_comb begin
    o_ctrl = cmb_pkg::ZERO16;
    o_ctrl[cmb_pkg::B_MUC] = q.buffer_update_in_progress;
    o_ctrl[cmb_pkg::B_MOW] = q.overwrite_occurred;
    o_ctrl[cmb_pkg::B_IE] = q.ie;
    o_ctrl[cmb_pkg::B_DN] = q.dn;
    o_ctrl[cmb_pkg::B_TRQ] = q.transmit_request;
    o_ctrl[cmb_pkg::B_RDY] = q.rdy;
  end

  assign o_rdy = q.rdy;
  assign o_trq = q.transmit_request;
  assign o_irq = q.irq;
endmodule // cmb_buf_ctrl

// file: tb/cmb_top_props.sv
// Checker of the message buffer control top ports.
// Bound to every cmb_top; single clock, synchronous reset.
`timescale 1ns/10ps
module cmb_top_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_bus_busy,
  input wire logic [3:0] i_store_start,
  input wire logic [3:0] i_store_end,
  input wire logic [3:0] i_tx_end,
  input wire logic [3:0] o_buf_irq,
  input wire logic [3:0] o_buf_rdy,
  input wire logic [3:0] o_buf_trq,
  input wire logic [2:0] o_operating_mode_field,
  input wire logic o_gom
);
  logic muc_q;
  logic pend_q;
  logic w1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  assign w1 = i_ce && i_wr && i_addr == 8'h11;
  // Storage window of buffer 1, and a pending init request
  always_ff @(posedge i_clk) begin
    if (i_rst || i_store_end[1]) begin
      muc_q <= 1'h0;
    end else if (i_store_start[1] && o_buf_rdy[1]) begin
      muc_q <= 1'h1;
    end
    if (i_rst || o_operating_mode_field == 3'h0) begin
      pend_q <= 1'h0;
    end else if (i_wr && i_addr == 8'h02 && i_wdata[2:0] == 3'h0) begin
      pend_q <= 1'h1;
    end
  end
  rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  rdy_set_a: assert property (w1 && i_wdata[8] && !i_wdata[0] && !muc_q
    |=> o_buf_rdy[1]) else $error("ready not set");
  rdy_clr_a: assert property (w1 && !i_wdata[8] && i_wdata[0] && !muc_q
    |=> !o_buf_rdy[1]) else $error("ready not cleared");
  trq_set_a: assert property (w1 && i_wdata[9] && !i_wdata[1]
    |=> o_buf_trq[1]) else $error("request not set");
  trq_clr_a: assert property (w1 && !i_wdata[9] && i_wdata[1]
    |=> !o_buf_trq[1]) else $error("request not cleared");
  trq_hold_a: assert property (!w1 && !i_tx_end[1]
    |=> $stable(o_buf_trq[1])) else $error("request changed alone");
  irq_cause_a: assert property (o_buf_irq[2]
    |-> $past(i_store_end[2]) || $past(i_store_end[2], 2))
    else $error("interrupt without completion");
  init_idle_a: assert property (o_operating_mode_field == 3'h0 && $past(o_gom)
    && $past(o_operating_mode_field) != 3'h0 |-> !$past(i_bus_busy))
    else $error("init entered inside a frame");
  init_soon_a: assert property (pend_q && !i_bus_busy
    |-> ##[0:1] o_operating_mode_field == 3'h0) else $error("init not entered");
  thru_init_a: assert property ($past(o_operating_mode_field) != 3'h0
    && o_operating_mode_field != $past(o_operating_mode_field) |-> o_operating_mode_field == 3'h0)
    else $error("direct change between run modes");
  gom_off_a: assert property (!o_gom |=> o_operating_mode_field == 3'h0)
    else $error("run mode while disabled");
endmodule // cmb_top_chk

bind cmb_top cmb_top_chk i_cmb_top_chk (.*);

// file: tb/cmb_can_node.sv
// Model of the other nodes on the CAN bus.
// Drives frame, store and transmit events just after rising edges.
`timescale 1ns/10ps
module cmb_can_node (
  input wire logic i_clk,
  output logic o_busy,
  output logic [3:0] o_ss,
  output logic [3:0] o_se,
  output logic o_rem,
  output logic [3:0] o_te,
  output logic o_tok
);
  initial begin
    {o_busy, o_ss, o_se, o_rem, o_te, o_tok} = '0;
  end
  task automatic st(input logic [1:0] m, input logic r);
    @(posedge i_clk);
    o_busy <= 1'h1;
    o_rem <= r;
    o_ss <= 4'h1 << m;
    @(posedge i_clk);
    o_ss <= 4'h0;
  endtask
  // Frame ends, bus returns to interframe space
  task automatic en(input logic [1:0] m);
    @(posedge i_clk);
    o_se <= 4'h1 << m;
    @(posedge i_clk);
    o_se <= 4'h0;
    o_rem <= ~o_rem;
    o_busy <= 1'h0;
  endtask
  task automatic tx(input logic [1:0] m, input logic ok);
    @(posedge i_clk);
    o_busy <= 1'h1;
    o_te <= 4'h1 << m;
    o_tok <= ok;
    @(posedge i_clk);
    o_te <= 4'h0;
    o_tok <= ~ok;
    o_busy <= 1'h0;
  endtask
  task automatic hold(input logic b);
    @(posedge i_clk);
    o_busy <= b;
  endtask
endmodule // cmb_can_node

// file: tb/cmb_top_bench.sv
// Self-checking bench of the message buffer control block.
// Drives the register port and a bus node model at 20 MHz.
`timescale 1ns/10ps
module cmb_top_bench;
  logic i_clk;
  logic i_rst;
  logic wr_s;
  logic rd_s;
  logic tec;
  logic ce;
  logic rinc;
  logic [3:0] ide;
  logic eevt;
  logic [2:0] ecode;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [3:0][28:0] ids;
  logic [15:0] rdata;
  logic [3:0] irq;
  logic [3:0] rdy;
  logic [3:0] transmit_request;
  logic txv;
  logic [1:0] txs;
  logic [2:0] opm;
  logic global_operation_enable;
  logic [3:0] pre;
  logic busy;
  logic [3:0] ss;
  logic [3:0] se;
  logic rem;
  logic [3:0] te;
  logic tok;
  logic [15:0] r;
  logic [15:0] m;
  logic [15:0] s;
  logic [15:0] w;
  logic [3:0] g;
  logic [15:0] cf [4] = '{16'h0001, 16'h0000, 16'h0009, 16'h0001};
  int mismatches;
  int n_checks;

  cmb_top i_cmb_top (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_bus_busy(busy), .i_store_start(ss),
    .i_store_end(se), .i_store_remote(rem), .i_tx_end(te),
    .i_tx_ok(tok), .i_buf_id(ids), .i_buf_ide(ide), .i_tec_inc(tec),
    .i_rec_inc(rinc), .i_err_evt(eevt), .i_err_code(ecode),
    .o_buf_irq(irq), .o_buf_rdy(rdy), .o_buf_trq(transmit_request),
    .o_tx_valid(txv), .o_tx_sel(txs), .o_operating_mode_field(opm), .o_gom(global_operation_enable),
    .o_prescale(pre));
  cmb_can_node i_cmb_can_node (.i_clk(i_clk), .o_busy(busy),
    .o_ss(ss), .o_se(se), .o_rem(rem), .o_te(te), .o_tok(tok));

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] v);
    n_checks++;
    if (v !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge i_clk);
    wr_s <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge i_clk);
    rd_s <= 1'h0;
    #1 r = rdata;
  endtask
  task automatic irqw;
    #1 g = irq;
    repeat (2) begin
      @(posedge i_clk);
      #1 g = g | irq;
    end
  endtask
  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected control word after a software write
  function automatic logic [15:0] nc(input logic [15:0] o, x);
    nc = o;
    if (!o[0] && x[11] != x[3]) nc[3] = x[11];
    if (x[9] != x[1]) nc[1] = x[9];
    if (x[8] != x[0]) nc[0] = x[8];
    if (x[4]) nc[4] = 1'h0;
    if (x[2]) nc[2] = 1'h0;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    complete_run;
  end

  initial begin
    i_rst = 1'h1;
    {wr_s, rd_s, tec, rinc, eevt, ecode, addr, wdata, ids, ide} = '0;
    ce = 1'h1;
    ids[0] = 29'h1000_0000;
    ids[3] = 29'h0004_0000;
    s = 16'h004c;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    rd(8'h10);
    chk("ctrl reset", 16'h0000, r);
    rd(8'h17);
    chk("unmapped", 16'h0000, r);
    wr(8'h00, 16'h0003);
    wr(8'h01, 16'h0001);
    wr(8'h00, 16'h0005);
    chk("prescale", 16'h0003, {12'h000, pre});
    chk("enable", 16'h0001, {15'h0000, global_operation_enable});
    for (int k = 0; k < 4; k++) begin
      wr(8'h10 + k[7:0], 16'h0007);
      rd(8'h10 + k[7:0]);
      chk("ready clear", 16'h0000, {15'h0000, r[0]});
      wr(8'h20 + k[7:0], cf[k]);
    end
    // A write while the clock enable is low must leave no trace
    @(posedge i_clk);
    ce <= 1'h0;
    wr(8'h10, 16'h0100);
    @(posedge i_clk);
    ce <= 1'h1;
    rd(8'h10);
    chk("frozen", 16'h0000, r);
    for (int k = 1; k < 6; k++) begin
      wr(8'h02, 16'(k));
      chk("run mode", 16'(k), {13'h0000, opm});
      wr(8'h02, 16'h0000);
      chk("init mode", 16'h0000, {13'h0000, opm});
    end
    wr(8'h02, 16'h0001);
    wr(8'h02, 16'h0003);
    chk("direct mode", 16'h0001, {13'h0000, opm});
    @(posedge i_clk);
    tec <= 1'h1;
    rinc <= 1'h1;
    eevt <= 1'h1;
    ecode <= 3'h5;
    repeat (3) @(posedge i_clk);
    tec <= 1'h0;
    rinc <= 1'h0;
    eevt <= 1'h0;
    i_cmb_can_node.hold(1'h1);
    wr(8'h02, 16'h0000);
    chk("init pending", 16'h0001, {13'h0000, opm});
    i_cmb_can_node.hold(1'h0);
    repeat (2) @(posedge i_clk);
    #1 chk("init entered", 16'h0000, {13'h0000, opm});
    rd(8'h02);
    chk("mode poll", 16'h0000, r);
    rd(8'h03);
    chk("error count", 16'h0303, r);
    rd(8'h04);
    chk("bus info", 16'h0005, r);
    wr(8'h02, 16'h0100);
    rd(8'h03);
    chk("count cleared", 16'h0000, r);
    rd(8'h04);
    chk("info cleared", 16'h0000, r);
    wr(8'h02, 16'h0001);
    m = 16'h0000;
    repeat (24) begin
      s = lf(s);
      w = s & 16'hfbff;
      if (w[9] && (w[8] || !m[0])) w[9] = 1'h0;
      m = nc(m, w);
      wr(8'h11, w);
      rd(8'h11);
      chk("ctrl random", m, r);
    end
    wr(8'h13, 16'h0800);
    wr(8'h13, 16'h0100);
    wr(8'h10, 16'h0100);
    wr(8'h10, 16'h0200);
    repeat (2) @(posedge i_clk);
    #1 chk("tx single", 16'h0004, {13'h0000, txv, txs});
    wr(8'h13, 16'h0200);
    repeat (2) @(posedge i_clk);
    #1 chk("tx priority", 16'h0007, {13'h0000, txv, txs});
    // Same base identifier: the standard frame beats the extended one
    @(posedge i_clk);
    ids[0] <= 29'h0004_0000;
    ide <= 4'h8;
    repeat (2) @(posedge i_clk);
    #1 chk("tx format", 16'h0004, {13'h0000, txv, txs});
    i_cmb_can_node.tx(2'd3, 1'h1);
    irqw;
    chk("tx irq", 16'h0008, {12'h000, g});
    chk("tx done", {14'h0000, m[1], 1'h1}, {12'h000, transmit_request});
    // Release buffer 0 only once its transmission is over
    i_cmb_can_node.tx(2'd0, 1'h1);
    wr(8'h10, 16'h0001);
    chk("released", {12'h000, 2'h2, m[1] | m[0], 1'h0},
      {12'h000, transmit_request | rdy});
    wr(8'h12, 16'h0800);
    wr(8'h12, 16'h0100);
    wr(8'h22, 16'h0000);
    rd(8'h22);
    chk("conf locked", 16'h0009, r);
    i_cmb_can_node.st(2'd2, 1'h0);
    rd(8'h12);
    chk("storing", 16'h200d, r);
    i_cmb_can_node.en(2'd2);
    irqw;
    chk("rx irq", 16'h0004, {12'h000, g});
    rd(8'h12);
    chk("stored", 16'h000d, r);
    i_cmb_can_node.st(2'd2, 1'h0);
    i_cmb_can_node.en(2'd2);
    rd(8'h12);
    chk("overwrite", 16'h001d, r);
    wr(8'h12, 16'h0014);
    rd(8'h12);
    chk("flags cleared", 16'h0009, r);
    repeat (2) begin
      i_cmb_can_node.st(2'd2, 1'h1);
      i_cmb_can_node.en(2'd2);
    end
    rd(8'h12);
    chk("remote", 16'h000d, r);
    complete_run;
  end
endmodule // cmb_top_bench
